// ===== amc_pkg.sv
// constants for the audio converter mode control register bank
// Function
// - control word bit 15 low writes the register, high reads it back.
// - index 16 holds left gain code, index 17 holds right gain code.
// - level is half a decibel times code minus 255; 255 is unity.
// - codes 0 to 14 fully mute that channel.
// - both gain code registers read all ones after reset.
// - shared load gate in index 18 bit 7 allows new gain codes.
// - three-bit format field selects serial format; 101 after reset.
// - two-bit emphasis rate field: off, 48, 44.1 or 32 kHz.
// - in one-bit stream mode the emphasis field selects FIR response.
// - emphasis enable, clear after reset, acts on both channels.
// - soft mute ramps both channels to mute and back stepwise.
// - phase invert bit flips output polarity of both channels.
// - step rate field paces steps at word clock over 2,4,8,16.
// - output disable forces both outputs to bipolar zero.
// - in bypass mode, stereo select picks data pin or zero pins.
// - rolloff bit selects sharp (0) or slow (1) filter response.
// - filter bypass input skips the internal interpolation filter.
// - one-bit stream input selects stream mode, else PCM input.
package amc_pkg;
	// control word layout
	localparam int RW_BIT    = 15;
	localparam int IDX_MSB   = 14;
	localparam int IDX_LSB   = 8;
	localparam int DATA_MSB  = 7;
	localparam int WORD_BITS = 16;
	localparam logic [4:0] WORD_COUNT = 5'h10;
	localparam logic [4:0] HEAD_COUNT = 5'h08;
	// register indexes
	localparam logic [6:0] IDX_LEFT_GAIN  = 7'h10;
	localparam logic [6:0] IDX_RIGHT_GAIN = 7'h11;
	localparam logic [6:0] IDX_FMT_MUTE   = 7'h12;
	localparam logic [6:0] IDX_OUT_FILT   = 7'h13;
	// format_emphasis_mute_control fields
	localparam int LOAD_GATE_BIT = 7;
	localparam int FMT_MSB       = 6;
	localparam int FMT_LSB       = 4;
	localparam int EMPH_MSB      = 3;
	localparam int EMPH_LSB      = 2;
	localparam int EMPH_EN_BIT   = 1;
	localparam int SOFT_MUTE_BIT = 0;
	// output_filter_control fields
	localparam int INVERT_BIT    = 7;
	localparam int STEP_MSB      = 6;
	localparam int STEP_LSB      = 5;
	localparam int OUT_DIS_BIT   = 4;
	localparam int RESERVED_BIT  = 3;
	localparam int STEREO_BIT    = 2;
	localparam int ROLLOFF_BIT   = 1;
	localparam int ZERO_MUTE_BIT = 0;
	// values after reset
	localparam logic [7:0] GAIN_RESET     = 8'hff;
	localparam logic [7:0] FMT_MUTE_RESET = 8'h50;
	localparam logic [7:0] OUT_FILT_RESET = 8'h00;
	// attenuator thresholds
	localparam logic [7:0] MUTE_CODE_MAX  = 8'h0e;
	localparam logic [7:0] GAIN_FULL_MUTE = 8'h00;
	// step pacing: last word clock count of each divider
	localparam logic [3:0] STEP_LAST_DIV2  = 4'h1;
	localparam logic [3:0] STEP_LAST_DIV4  = 4'h3;
	localparam logic [3:0] STEP_LAST_DIV8  = 4'h7;
	localparam logic [3:0] STEP_LAST_DIV16 = 4'hf;
	// serial audio formats
	typedef enum logic [2:0] {
		FMT_RJ16  = 3'h0,
		FMT_RJ20  = 3'h1,
		FMT_RJ24  = 3'h2,
		FMT_LJ24  = 3'h3,
		FMT_I2S16 = 3'h4,
		FMT_I2S24 = 3'h5,
		FMT_RSV6  = 3'h6,
		FMT_RSV7  = 3'h7
	} amc_format_t;
endpackage

// ===== amc_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module amc_sync #(
	parameter int               WIDTH     = 6,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// asynchronous in, synchronous out
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta;

	// first stage is read by the second stage only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta     <= RESET_VAL;
			sync_out <= RESET_VAL;
		end else begin
			meta     <= async_in;
			sync_out <= meta;
		end
	end
endmodule // amc_sync

// ===== amc_gain_ramp.sv
// one channel of the stepping attenuator
`timescale 1ns/1ps
module amc_gain_ramp (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// control
	input  wire logic       step,
	input  wire logic [7:0] goal,
	// state
	output logic      [7:0] level,
	output logic            muted
);
	// one code per step toward the goal, so moves stay click free
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			level <= amc_pkg::GAIN_RESET;
		end else if (step && level < goal) begin
			level <= level + 8'h01;
		end else if (step && level > goal) begin
			level <= level - 8'h01;
		end
	end

	// low codes are full mute
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			muted <= 1'b0;
		end else begin
			muted <= (level <= amc_pkg::MUTE_CODE_MAX);
		end
	end
endmodule // amc_gain_ramp

// ===== amc_mode_regs.sv
// mode control register bank with serial control port and attenuators
`timescale 1ns/1ps
module amc_mode_regs (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset_n,
	// serial control port
	input  wire logic       ctrl_cs_n,
	input  wire logic       ctrl_sclk,
	input  wire logic       ctrl_mosi,
	output logic            ctrl_miso,
	output logic            ctrl_miso_oe_n,
	// audio timing and mode inputs
	input  wire logic       word_clock,
	input  wire logic       filter_bypass_select,
	input  wire logic       one_bit_stream_mode,
	// attenuator state
	output logic      [7:0] left_level,
	output logic      [7:0] right_level,
	output logic            left_muted,
	output logic            right_muted,
	// mode outputs
	output logic      [2:0] audio_format_select,
	output logic            format_reserved,
	output logic      [1:0] emphasis_rate_select,
	output logic            emphasis_enable,
	output logic      [1:0] fir_response_select,
	output logic            phase_invert,
	output logic            bipolar_zero_level,
	output logic            rolloff_select,
	output logic            interpolation_bypass,
	output logic            bypass_mono_input,
	output logic            bypass_stereo_input,
	output logic            pcm_input_mode
);
	logic       rst_meta;
	logic       rst_n;
	logic [5:0] pins_s;
	logic       cs_n_s;
	logic       sclk_s;
	logic       mosi_s;
	logic       wclk_s;
	logic       bypass_s;
	logic       stream_s;
	logic       sclk_q;
	logic       cs_q;
	logic       wclk_q;
	logic       sclk_rise;
	logic       sclk_fall;
	logic       cs_rise;
	logic [4:0] bit_cnt;
	logic [15:0] shift_in;
	logic [7:0] shift_out;
	logic       frame_done;
	logic       wr_frame;
	logic [6:0] wr_index;
	logic [7:0] wr_data;
	logic [7:0] rd_data;
	logic [7:0] left_gain_code;
	logic [7:0] right_gain_code;
	logic [7:0] left_target;
	logic [7:0] right_target;
	logic [7:0] fmt_mute_reg;
	logic [7:0] out_filt_reg;
	logic       gain_load_gate;
	logic       soft_mute;
	logic [1:0] gain_step_rate;
	logic       bypass_stereo_select;
	logic [3:0] step_cnt;
	logic [3:0] step_last;
	logic       step_tick;
	logic [7:0] goal [2];
	logic [7:0] level [2];
	logic       muted [2];
	localparam int WORD_BITS_M1 = amc_pkg::WORD_BITS - 2;

	// reset release through two flops
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// every pin passes two flops before use; select resets to its idle high
	amc_sync #(
		.WIDTH    (6),
		.RESET_VAL(6'h20)
	) u_sync (
		.clk     (clk),
		.rst_n   (rst_n),
		.async_in({ctrl_cs_n, ctrl_sclk, ctrl_mosi, word_clock,
			filter_bypass_select, one_bit_stream_mode}),
		.sync_out(pins_s)
	);
	assign cs_n_s   = pins_s[5];
	assign sclk_s   = pins_s[4];
	assign mosi_s   = pins_s[3];
	assign wclk_s   = pins_s[2];
	assign bypass_s = pins_s[1];
	assign stream_s = pins_s[0];

	// edge history of synchronised pins; select idles high
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_q <= 1'b0;
			cs_q   <= 1'b1;
			wclk_q <= 1'b0;
		end else begin
			sclk_q <= sclk_s;
			cs_q   <= cs_n_s;
			wclk_q <= wclk_s;
		end
	end

	assign sclk_rise = !cs_n_s && sclk_s && !sclk_q;
	assign sclk_fall = !cs_n_s && !sclk_s && sclk_q;
	assign cs_rise   = cs_n_s && !cs_q;

	// input shifter, most significant bit first, sampled on rising clock
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bit_cnt  <= 5'h00;
			shift_in <= 16'h0000;
		end else if (cs_n_s) begin
			bit_cnt <= 5'h00;
		end else if (sclk_rise) begin
			shift_in <= {shift_in[WORD_BITS_M1:0], mosi_s};
			if (bit_cnt != amc_pkg::WORD_COUNT) begin
				bit_cnt <= bit_cnt + 5'h01;
			end
		end
	end

	// a frame counts only if at least sixteen bits arrived; the bit count stops at sixteen
	assign frame_done = cs_rise && (bit_cnt == amc_pkg::WORD_COUNT);
	assign wr_frame   = frame_done && !shift_in[amc_pkg::RW_BIT];
	assign wr_index   = shift_in[amc_pkg::IDX_MSB:amc_pkg::IDX_LSB];
	assign wr_data    = shift_in[amc_pkg::DATA_MSB:0];

	// readback mux; unmapped indexes and the spare bit read zero
	always_comb begin
		case (shift_in[6:0])
		amc_pkg::IDX_LEFT_GAIN:  rd_data = left_gain_code;
		amc_pkg::IDX_RIGHT_GAIN: rd_data = right_gain_code;
		amc_pkg::IDX_FMT_MUTE:   rd_data = fmt_mute_reg;
		amc_pkg::IDX_OUT_FILT:   rd_data = out_filt_reg;
		default:                 rd_data = 8'h00;
		endcase
	end

	// output shifter: after the header, a read returns data on falling clock
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_out <= 8'h00;
			ctrl_miso <= 1'b0;
		end else if (cs_n_s) begin
			ctrl_miso <= 1'b0;
		end else if (sclk_fall) begin
			if (bit_cnt == amc_pkg::HEAD_COUNT && shift_in[7]) begin
				ctrl_miso <= rd_data[7];
				shift_out <= {rd_data[6:0], 1'b0};
			end else if (bit_cnt > amc_pkg::HEAD_COUNT) begin
				ctrl_miso <= shift_out[7];
				shift_out <= {shift_out[6:0], 1'b0};
			end else begin
				ctrl_miso <= 1'b0;
				shift_out <= 8'h00;
			end
		end
	end

	// data line is driven only while selected
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_miso_oe_n <= 1'b1;
		end else begin
			ctrl_miso_oe_n <= cs_n_s;
		end
	end

	// gain code registers hold what the host wrote
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			left_gain_code  <= amc_pkg::GAIN_RESET;
			right_gain_code <= amc_pkg::GAIN_RESET;
		end else if (wr_frame && wr_index == amc_pkg::IDX_LEFT_GAIN) begin
			left_gain_code <= wr_data;
		end else if (wr_frame && wr_index == amc_pkg::IDX_RIGHT_GAIN) begin
			right_gain_code <= wr_data;
		end
	end

	// active targets follow new codes only while the load gate is set
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			left_target  <= amc_pkg::GAIN_RESET;
			right_target <= amc_pkg::GAIN_RESET;
		end else if (wr_frame && gain_load_gate) begin
			if (wr_index == amc_pkg::IDX_LEFT_GAIN) begin
				left_target <= wr_data;
			end
			if (wr_index == amc_pkg::IDX_RIGHT_GAIN) begin
				right_target <= wr_data;
			end
		end
	end

	// control registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fmt_mute_reg <= amc_pkg::FMT_MUTE_RESET;
			out_filt_reg <= amc_pkg::OUT_FILT_RESET;
		end else if (wr_frame && wr_index == amc_pkg::IDX_FMT_MUTE) begin
			fmt_mute_reg <= wr_data;
		end else if (wr_frame && wr_index == amc_pkg::IDX_OUT_FILT) begin
			out_filt_reg <= wr_data & ~(8'h01 << amc_pkg::RESERVED_BIT);
		end
	end

	assign gain_load_gate       = fmt_mute_reg[amc_pkg::LOAD_GATE_BIT];
	assign soft_mute            = fmt_mute_reg[amc_pkg::SOFT_MUTE_BIT];
	assign gain_step_rate       = out_filt_reg[amc_pkg::STEP_MSB:
		amc_pkg::STEP_LSB];
	assign bypass_stereo_select = out_filt_reg[amc_pkg::STEREO_BIT];

	// step divider length from the rate field
	always_comb begin
		case (gain_step_rate)
		2'h0:    step_last = amc_pkg::STEP_LAST_DIV2;
		2'h1:    step_last = amc_pkg::STEP_LAST_DIV4;
		2'h2:    step_last = amc_pkg::STEP_LAST_DIV8;
		default: step_last = amc_pkg::STEP_LAST_DIV16;
		endcase
	end

	// count word clock rising edges; one step per full divide
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			step_cnt  <= 4'h0;
			step_tick <= 1'b0;
		end else if (wclk_s && !wclk_q) begin
			step_tick <= (step_cnt >= step_last);
			step_cnt  <= (step_cnt >= step_last) ? 4'h0 : step_cnt + 4'h1;
		end else begin
			step_tick <= 1'b0;
		end
	end

	// soft mute steers both channels toward full mute, release returns
	assign goal[0] = soft_mute ? amc_pkg::GAIN_FULL_MUTE : left_target;
	assign goal[1] = soft_mute ? amc_pkg::GAIN_FULL_MUTE : right_target;

	// one stepping attenuator per channel
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_chan
			amc_gain_ramp u_ramp (
				.clk  (clk),
				.rst_n(rst_n),
				.step (step_tick),
				.goal (goal[ch]),
				.level(level[ch]),
				.muted(muted[ch])
			);
		end
	endgenerate

	assign left_level  = level[0];
	assign right_level = level[1];
	assign left_muted  = muted[0];
	assign right_muted = muted[1];

	// registered mode outputs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			audio_format_select  <= amc_pkg::FMT_I2S24;
			format_reserved      <= 1'b0;
			emphasis_rate_select <= 2'h0;
			emphasis_enable      <= 1'b0;
			fir_response_select  <= 2'h0;
			phase_invert         <= 1'b0;
			bipolar_zero_level   <= 1'b0;
			rolloff_select       <= 1'b0;
			interpolation_bypass <= 1'b0;
			bypass_mono_input    <= 1'b0;
			bypass_stereo_input  <= 1'b0;
			pcm_input_mode       <= 1'b1;
		end else begin
			audio_format_select <= fmt_mute_reg[amc_pkg::FMT_MSB:
				amc_pkg::FMT_LSB];
			format_reserved <= (fmt_mute_reg[amc_pkg::FMT_MSB:
				amc_pkg::FMT_LSB] >= amc_pkg::FMT_RSV6);
			emphasis_rate_select <= stream_s ? 2'h0 :
				fmt_mute_reg[amc_pkg::EMPH_MSB:amc_pkg::EMPH_LSB];
			emphasis_enable <= !stream_s &&
				fmt_mute_reg[amc_pkg::EMPH_EN_BIT];
			fir_response_select <= stream_s ?
				fmt_mute_reg[amc_pkg::EMPH_MSB:amc_pkg::EMPH_LSB] :
				2'h0;
			phase_invert       <= out_filt_reg[amc_pkg::INVERT_BIT];
			bipolar_zero_level <= out_filt_reg[amc_pkg::OUT_DIS_BIT];
			rolloff_select     <= out_filt_reg[amc_pkg::ROLLOFF_BIT];
			interpolation_bypass <= bypass_s;
			bypass_mono_input    <= bypass_s && !bypass_stereo_select;
			bypass_stereo_input  <= bypass_s && bypass_stereo_select;
			pcm_input_mode       <= !stream_s;
		end
	end
endmodule // amc_mode_regs

// ===== amc_mode_regs_sva.sv
// port assertions for the mode control register bank
`timescale 1ns/1ps
module amc_mode_regs_chk (
	// clock and reset
	input wire logic       clk,
	input wire logic       reset_n,
	// control port
	input wire logic       ctrl_cs_n,
	input wire logic       ctrl_miso,
	input wire logic       ctrl_miso_oe_n,
	// attenuator state
	input wire logic [7:0] left_level,
	input wire logic [7:0] right_level,
	input wire logic       left_muted,
	input wire logic       right_muted,
	// mode outputs
	input wire logic [2:0] audio_format_select,
	input wire logic       format_reserved,
	input wire logic [1:0] emphasis_rate_select,
	input wire logic       emphasis_enable,
	input wire logic [1:0] fir_response_select,
	input wire logic       interpolation_bypass,
	input wire logic       bypass_mono_input,
	input wire logic       bypass_stereo_input,
	input wire logic       pcm_input_mode
);
	// one clock domain, reset pin disables all checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	// read line parked low whenever it is not driven
	miso_idle_a: assert property (ctrl_miso_oe_n |-> !ctrl_miso)
		else $error("read line not low while released");
	// output enable follows the select within a few clocks
	oe_follow_a: assert property ($fell(ctrl_cs_n) |-> ##[1:4] !ctrl_miso_oe_n)
		else $error("read line not enabled after select");
	oe_release_a: assert property ($rose(ctrl_cs_n) |-> ##[1:4] ctrl_miso_oe_n)
		else $error("read line not released after select");
	// attenuators move one code per step at most
	left_step_a: assert property (left_level != $past(left_level) |->
		(8'(left_level - $past(left_level)) == 8'h01) ||
		(8'(8'($past(left_level)) - left_level) == 8'h01))
		else $error("left level jumped more than one code");
	right_step_a: assert property (right_level != $past(right_level) |->
		(8'(right_level - $past(right_level)) == 8'h01) ||
		(8'(8'($past(right_level)) - right_level) == 8'h01))
		else $error("right level jumped more than one code");
	// mute flags follow the level one clock later
	mute_flag_a: assert property (
		left_muted == ($past(left_level) <= 8'h0e) &&
		right_muted == ($past(right_level) <= 8'h0e))
		else $error("mute flag disagrees with level");
	// reserved format codes are flagged
	fmt_rsv_a: assert property (
		format_reserved == (audio_format_select[2:1] == 2'b11))
		else $error("reserved format flag wrong");
	// emphasis field drives either emphasis or the stream filter
	stream_split_a: assert property (
		(pcm_input_mode && $past(pcm_input_mode) |-> fir_response_select == 2'b00)
		and (!pcm_input_mode && !$past(pcm_input_mode) |->
		!emphasis_enable && emphasis_rate_select == 2'b00))
		else $error("emphasis and stream filter overlap");
	// bypass input select is exclusive and only in bypass mode
	bypass_excl_a: assert property (!(bypass_mono_input && bypass_stereo_input)
		&& ((bypass_mono_input || bypass_stereo_input) ==
		interpolation_bypass))
		else $error("bypass input select wrong");
endmodule // amc_mode_regs_chk

bind amc_mode_regs amc_mode_regs_chk CHK (
	.clk, .reset_n, .ctrl_cs_n, .ctrl_miso, .ctrl_miso_oe_n, .left_level,
	.right_level, .left_muted, .right_muted, .audio_format_select,
	.format_reserved, .emphasis_rate_select, .emphasis_enable,
	.fir_response_select, .interpolation_bypass, .bypass_mono_input,
	.bypass_stereo_input, .pcm_input_mode
);

// ===== amc_host.sv
// host controller model for the serial control port
`timescale 1ns/1ps
module amc_host (
	// clock
	input  wire logic clk,
	// control port
	output logic      cs_n,
	output logic      sclk,
	output logic      mosi,
	input  wire logic miso
);
	// idle: deselected, bit clock parked low
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		mosi = 1'b0;
	end
	// wait n clocks, then step past the edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	// one 16-bit frame msb first, read bits taken at rising bit clock
	task automatic xfer(input logic [15:0] w, output logic [7:0] r);
		r = 8'h00;
		tick(1);
		cs_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			mosi = w[i];
			tick(5);
			sclk = 1'b1;
			if (i < 8)
				r[i] = miso;
			tick(5);
			sclk = 1'b0;
		end
		cs_n = 1'b1;
		mosi = ~mosi; // released line shows no stale value
		tick(5);
	endtask
endmodule // amc_host

// ===== test_audio_dac_mode_control_regs.sv
// self-checking bench for the mode control register bank
`timescale 1ns/1ps
module test_audio_dac_mode_control_regs;
	// pins
	logic       clk = 1'b0;
	logic       reset_n = 1'b0;
	logic       word_clock = 1'b0;
	logic       filter_bypass_select = 1'b0;
	logic       one_bit_stream_mode = 1'b0;
	logic       ctrl_cs_n, ctrl_sclk, ctrl_mosi, ctrl_miso, ctrl_miso_oe_n;
	logic [7:0] left_level, right_level;
	logic       left_muted, right_muted, format_reserved, emphasis_enable;
	logic [2:0] audio_format_select;
	logic [1:0] emphasis_rate_select, fir_response_select;
	logic       phase_invert, bipolar_zero_level, rolloff_select;
	logic       interpolation_bypass, bypass_mono_input, bypass_stereo_input;
	logic       pcm_input_mode;
	int         num_errors = 0;
	int         comparisons = 0;
	int         cyc = 0;
	int         g;

	amc_mode_regs DUT (
		.clk, .reset_n, .ctrl_cs_n, .ctrl_sclk, .ctrl_mosi, .ctrl_miso,
		.ctrl_miso_oe_n, .word_clock, .filter_bypass_select,
		.one_bit_stream_mode, .left_level, .right_level, .left_muted,
		.right_muted, .audio_format_select, .format_reserved,
		.emphasis_rate_select, .emphasis_enable, .fir_response_select,
		.phase_invert, .bipolar_zero_level, .rolloff_select,
		.interpolation_bypass, .bypass_mono_input, .bypass_stereo_input,
		.pcm_input_mode
	);
	amc_host HOST (
		.clk, .cs_n(ctrl_cs_n), .sclk(ctrl_sclk), .mosi(ctrl_mosi),
		.miso(ctrl_miso)
	);
	// 20 MHz clock and a word clock rising every 8 clocks
	initial begin
		forever #25 clk = ~clk;
	end
	initial begin
		forever begin
			repeat (4) @(posedge clk);
			#2 word_clock = ~word_clock;
		end
	end
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			num_errors++;
			final_report();
		end
	end
	task automatic final_report;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] v);
		comparisons++;
		if (v !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, v);
		end
	endtask
	// register write, then let outputs follow
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] r;
		HOST.xfer({1'b0, a, d}, r);
		tick(4);
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] r;
		HOST.xfer({1'b1, a, 8'h00}, r);
		chk("readback", e, r);
	endtask
	// bounded wait for both attenuators to reach their goals
	task automatic settle(input logic [7:0] l, input logic [7:0] r);
		int n;
		n = 0;
		while ((left_level !== l || right_level !== r) && n < 9000) begin
			tick(1);
			n++;
		end
		tick(1); // mute flags follow the level one clock later
		chk("left level", l, left_level);
		chk("right level", r, right_level);
	endtask
	// clocks until the right level next moves
	task automatic gap(output int c);
		logic [7:0] v;
		c = 0;
		v = right_level;
		while (right_level === v && c < 400) begin
			tick(1);
			c++;
		end
	endtask

	// main sequence
	initial begin
		repeat (16) @(posedge clk);
		#2 reset_n = 1'b1;
		tick(6);
		rd(7'h10, 8'hff);
		rd(7'h11, 8'hff);
		rd(7'h12, 8'h50);
		rd(7'h13, 8'h00);
		rd(7'h14, 8'h00);
		// gate clear: code stored but level kept
		wr(7'h10, 8'h80);
		rd(7'h10, 8'h80);
		tick(40);
		chk("left level", 8'hff, left_level);
		// gate open: independent codes, mute region
		wr(7'h12, 8'hd0);
		wr(7'h10, 8'h0e);
		wr(7'h11, 8'hf0);
		settle(8'h0e, 8'hf0);
		chk("left muted", 8'h01, 8'(left_muted));
		chk("right muted", 8'h00, 8'(right_muted));
		for (int f = 0; f < 8; f++) begin
			wr(7'h12, {1'b1, 3'(f), 4'h0});
			chk("format", 8'(f), 8'(audio_format_select));
			chk("fmt rsv", 8'(f >= 6), 8'(format_reserved));
		end
		for (int d = 0; d < 4; d++) begin
			wr(7'h12, {4'hd, 2'(d), 2'h2});
			chk("emph rate", 8'(d), 8'(emphasis_rate_select));
			chk("emph on", 8'h01, 8'(emphasis_enable));
			one_bit_stream_mode = 1'b1;
			tick(5);
			chk("fir select", 8'(d), 8'(fir_response_select));
			chk("pcm mode", 8'h00, 8'(pcm_input_mode));
			chk("emph off", 8'h00, 8'(emphasis_enable));
			chk("emph rate off", 8'h00, 8'(emphasis_rate_select));
			one_bit_stream_mode = 1'b0;
			tick(5);
		end
		wr(7'h12, 8'hd0);
		wr(7'h13, 8'hff);
		rd(7'h13, 8'hf7);
		chk("invert", 8'h01, 8'(phase_invert));
		chk("bpz", 8'h01, 8'(bipolar_zero_level));
		chk("rolloff", 8'h01, 8'(rolloff_select));
		filter_bypass_select = 1'b1;
		tick(5);
		chk("stereo in", 8'h01, 8'(bypass_stereo_input));
		chk("bypass", 8'h01, 8'(interpolation_bypass));
		wr(7'h13, 8'h00);
		chk("mono in", 8'h01, 8'(bypass_mono_input));
		chk("rolloff", 8'h00, 8'(rolloff_select));
		filter_bypass_select = 1'b0;
		// step pacing for each rate during a soft mute ramp
		for (int r = 0; r < 4; r++) begin
			wr(7'h13, 8'(r << 5));
			wr(7'h12, 8'hd1);
			gap(g);
			gap(g);
			chk("step gap", 8'(2 << r), 8'(g / 8));
			wr(7'h12, 8'hd0);
		end
		wr(7'h13, 8'h00);
		wr(7'h12, 8'hd1);
		settle(8'h00, 8'h00);
		chk("right muted", 8'h01, 8'(right_muted));
		wr(7'h12, 8'hd0);
		settle(8'h0e, 8'hf0);
		final_report();
	end
endmodule // test_audio_dac_mode_control_regs
